// [shared/cbx_pkg.sv]
package cbx_pkg;
  // ----------------------------------------------------------------
  // Operation codes presented by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CBX_OP_NOP = 5'h00,
    CBX_OP_IN = 5'h01,
    CBX_OP_OUT = 5'h02,
    CBX_OP_PUSH = 5'h03,
    CBX_OP_POP = 5'h04,
    CBX_OP_PMSTORE = 5'h05,
    CBX_OP_SHL = 5'h06,
    CBX_OP_SHR = 5'h07,
    CBX_OP_ROTL = 5'h08,
    CBX_OP_ROTR = 5'h09,
    CBX_OP_SRA = 5'h0a,
    CBX_OP_SWAP = 5'h0b,
    CBX_OP_FSET = 5'h0c,
    CBX_OP_FCLR = 5'h0d,
    CBX_OP_IOSET = 5'h0e,
    CBX_OP_IOCLR = 5'h0f,
    CBX_OP_TSTORE = 5'h10,
    CBX_OP_TLOAD = 5'h11,
    CBX_OP_BRK = 5'h12,
    CBX_OP_SLEEP = 5'h13,
    CBX_OP_WDOG = 5'h14
  } cbx_op_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBX_ST_IDLE = 3'b001,
    CBX_ST_POP = 3'b010,
    CBX_ST_PMW = 3'b100
  } cbx_state_t;

  // ----------------------------------------------------------------
  // Status flag positions and reset values
  // ----------------------------------------------------------------
  localparam int CBX_FLAG_C = 0;
  localparam int CBX_FLAG_Z = 1;
  localparam int CBX_FLAG_N = 2;
  localparam int CBX_FLAG_V = 3;
  localparam int CBX_FLAG_S = 4;
  localparam int CBX_FLAG_H = 5;
  localparam int CBX_FLAG_T = 6;
  localparam int CBX_FLAG_I = 7;
  localparam logic [7:0] CBX_FLAGS_RST = 8'h00;
  localparam logic [15:0] CBX_SP_RST = 16'h3fff;

  // ----------------------------------------------------------------
  // Timing counts at 100 MHz
  // ----------------------------------------------------------------
  localparam logic [1:0] CBX_POP_CYCLES = 2'h2;
  localparam logic [1:0] CBX_SRAM_EXTRA = 2'h1;
  localparam logic [15:0] CBX_PM_STEP = 16'h0002;
endpackage

// [hw/cbx_exec.sv]
// Functional notes
// - Program store writes R1:R0 at extended Z, then Z low advances by 2.
// - I/O read and I/O write finish in one cycle, flags untouched.
// - Push takes one cycle, pop three, no flag changes.
// - Left shift fills zero, rotate fills carry; old bit 7 to C; ZCNVH.
// - Right shifts: old bit 0 to C; zero, carry or bit7 fill; ZCNV.
// - I/O bit set forces the chosen bit to one in one cycle.
// - I/O bit clear forces the chosen bit to zero in one cycle.
// - Bit store copies chosen register bit to T, only T changes.
// - Bit load copies T to chosen register bit, flags untouched.
// - Flag set and clear write only the named flag in one cycle.
// - Break, no-op, sleep, watchdog restart issue in one cycle.
// - Cycle counts hold for internal memory; external RAM may stretch them.
// - Pop from internal SRAM costs one extra cycle.
`timescale 1ns/1ps
`default_nettype none
module cbx_exec
  import cbx_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic op_valid,
  output logic op_ready,
  input wire cbx_pkg::cbx_op_t op_code,
  input wire logic [DW-1:0] op_reg,
  input wire logic [2:0] op_bit,
  input wire logic [5:0] op_io_addr,
  input wire logic [DW-1:0] r0_val,
  input wire logic [DW-1:0] r1_val,
  input wire logic [15:0] z_val,
  input wire logic [7:0] z_pointer_extension,
  input wire logic [DW-1:0] io_rdata,
  input wire logic [DW-1:0] dmem_rdata,
  input wire logic dmem_external,
  input wire logic dmem_ready,
  input wire logic pm_done,
  output logic op_done,
  output logic [DW-1:0] rd_wdata,
  output logic rd_we,
  output logic [5:0] io_addr,
  output logic [DW-1:0] io_wdata,
  output logic io_we,
  output logic [AW-1:0] dmem_addr,
  output logic [DW-1:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  output logic [23:0] pm_addr,
  output logic [15:0] pm_wdata,
  output logic pm_we,
  output logic [15:0] z_wdata,
  output logic z_we,
  output logic [7:0] status_flags_register,
  output logic [AW-1:0] stack_ptr,
  output logic break_req,
  output logic sleep_req,
  output logic watchdog_restart
);
  import cbx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cbx_state_t st;
    logic [1:0] cnt;
    logic [7:0] flags;
    logic [AW-1:0] sp;
    logic done;
    logic [DW-1:0] rdw;
    logic rdwe;
    logic [5:0] ioa;
    logic [DW-1:0] iow;
    logic iowe;
    logic [AW-1:0] da;
    logic [DW-1:0] dw;
    logic dwe;
    logic dre;
    logic [23:0] pma;
    logic [15:0] pmw;
    logic pmwe;
    logic [15:0] zw;
    logic zwe;
    logic brk;
    logic slp;
    logic wdog;
  } cbx_regs_t;

  cbx_regs_t s_reg;
  cbx_regs_t s_next;
  logic take;

  function automatic logic [DW-1:0] bit_mask(input logic [2:0] b);
    bit_mask = DW'(1) << b;
  endfunction

  // Shared flag update for shifts; H only meaningful for left forms
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [DW-1:0] res,
                                             input logic c, input logic h, input logic upd_h);
    logic [7:0] o;
    o = f;
    o[CBX_FLAG_C] = c;
    o[CBX_FLAG_Z] = (res == '0);
    o[CBX_FLAG_N] = res[DW-1];
    o[CBX_FLAG_V] = res[DW-1] ^ c;
    if (upd_h) begin
      o[CBX_FLAG_H] = h;
    end
    shift_flags = o;
  endfunction

  assign take = ce && op_valid && (s_reg.st == CBX_ST_IDLE);
  assign op_ready = (s_reg.st == CBX_ST_IDLE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [DW-1:0] res;
    logic cin;
    res = '0;
    cin = s_reg.flags[CBX_FLAG_C];
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rdwe = 1'b0;
    s_next.iowe = 1'b0;
    s_next.dwe = 1'b0;
    s_next.dre = 1'b0;
    s_next.pmwe = 1'b0;
    s_next.zwe = 1'b0;
    s_next.brk = 1'b0;
    s_next.slp = 1'b0;
    s_next.wdog = 1'b0;
    case (s_reg.st)
      CBX_ST_IDLE: begin
        if (take) begin
          s_next.done = 1'b1;
          case (op_code)
            CBX_OP_IN: begin
              s_next.rdw = io_rdata;
              s_next.rdwe = 1'b1;
              s_next.ioa = op_io_addr;
            end
            CBX_OP_OUT: begin
              s_next.ioa = op_io_addr;
              s_next.iow = op_reg;
              s_next.iowe = 1'b1;
            end
            CBX_OP_PUSH: begin
              s_next.da = s_reg.sp;
              s_next.dw = op_reg;
              s_next.dwe = 1'b1;
              s_next.sp = s_reg.sp - AW'(1);
            end
            CBX_OP_POP: begin
              s_next.done = 1'b0;
              s_next.sp = s_reg.sp + AW'(1);
              s_next.da = s_reg.sp + AW'(1);
              s_next.dre = 1'b1;
              s_next.st = CBX_ST_POP;
              // Internal SRAM adds a cycle; external waits on ready instead
              // Take edge and finishing edge both count, so the wait is two short
              if (dmem_external) begin
                s_next.cnt = CBX_POP_CYCLES - 2'h2;
              end else begin
                s_next.cnt = CBX_POP_CYCLES - 2'h2 + CBX_SRAM_EXTRA;
              end
            end
            CBX_OP_PMSTORE: begin
              s_next.done = 1'b0;
              s_next.pma = {z_pointer_extension, z_val};
              s_next.pmw = {r1_val, r0_val};
              s_next.pmwe = 1'b1;
              s_next.st = CBX_ST_PMW;
            end
            CBX_OP_SHL: begin
              res = {op_reg[DW-2:0], 1'b0};
              s_next.rdw = res;
              s_next.rdwe = 1'b1;
              s_next.flags = shift_flags(s_reg.flags, res, op_reg[DW-1], op_reg[3], 1'b1);
            end
            CBX_OP_ROTL: begin
              res = {op_reg[DW-2:0], cin};
              s_next.rdw = res;
              s_next.rdwe = 1'b1;
              s_next.flags = shift_flags(s_reg.flags, res, op_reg[DW-1], op_reg[3], 1'b1);
            end
            CBX_OP_SHR: begin
              res = {1'b0, op_reg[DW-1:1]};
              s_next.rdw = res;
              s_next.rdwe = 1'b1;
              s_next.flags = shift_flags(s_reg.flags, res, op_reg[0], 1'b0, 1'b0);
            end
            CBX_OP_ROTR: begin
              res = {cin, op_reg[DW-1:1]};
              s_next.rdw = res;
              s_next.rdwe = 1'b1;
              s_next.flags = shift_flags(s_reg.flags, res, op_reg[0], 1'b0, 1'b0);
            end
            CBX_OP_SRA: begin
              res = {op_reg[DW-1], op_reg[DW-1:1]};
              s_next.rdw = res;
              s_next.rdwe = 1'b1;
              s_next.flags = shift_flags(s_reg.flags, res, op_reg[0], 1'b0, 1'b0);
            end
            CBX_OP_SWAP: begin
              s_next.rdw = {op_reg[3:0], op_reg[7:4]};
              s_next.rdwe = 1'b1;
            end
            CBX_OP_FSET: begin
              s_next.flags = s_reg.flags | bit_mask(op_bit);
            end
            CBX_OP_FCLR: begin
              s_next.flags = s_reg.flags & ~bit_mask(op_bit);
            end
            CBX_OP_IOSET: begin
              // Read-modify-write relies on io_rdata matching op_io_addr this cycle
              s_next.ioa = op_io_addr;
              s_next.iow = io_rdata | bit_mask(op_bit);
              s_next.iowe = 1'b1;
            end
            CBX_OP_IOCLR: begin
              s_next.ioa = op_io_addr;
              s_next.iow = io_rdata & ~bit_mask(op_bit);
              s_next.iowe = 1'b1;
            end
            CBX_OP_TSTORE: begin
              s_next.flags[CBX_FLAG_T] = op_reg[op_bit];
            end
            CBX_OP_TLOAD: begin
              s_next.rdw = op_reg;
              s_next.rdw[op_bit] = s_reg.flags[CBX_FLAG_T];
              s_next.rdwe = 1'b1;
            end
            CBX_OP_BRK: begin
              s_next.brk = 1'b1;
            end
            CBX_OP_SLEEP: begin
              s_next.slp = 1'b1;
            end
            CBX_OP_WDOG: begin
              s_next.wdog = 1'b1;
            end
            default: begin
              s_next.done = 1'b1;
            end
          endcase
        end
      end
      CBX_ST_POP: begin
        if (s_reg.cnt != 2'h0) begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end else if (!dmem_external || dmem_ready) begin
          s_next.rdw = dmem_rdata;
          s_next.rdwe = 1'b1;
          s_next.done = 1'b1;
          s_next.st = CBX_ST_IDLE;
        end
      end
      CBX_ST_PMW: begin
        if (pm_done) begin
          s_next.zw = z_val + CBX_PM_STEP;
          s_next.zwe = 1'b1;
          s_next.done = 1'b1;
          s_next.st = CBX_ST_IDLE;
        end
      end
      default: begin
        s_next.st = CBX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{st: CBX_ST_IDLE, flags: CBX_FLAGS_RST, sp: AW'(CBX_SP_RST), default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign op_done = s_reg.done;
  assign rd_wdata = s_reg.rdw;
  assign rd_we = s_reg.rdwe;
  assign io_addr = s_reg.ioa;
  assign io_wdata = s_reg.iow;
  assign io_we = s_reg.iowe;
  assign dmem_addr = s_reg.da;
  assign dmem_wdata = s_reg.dw;
  assign dmem_we = s_reg.dwe;
  assign dmem_re = s_reg.dre;
  assign pm_addr = s_reg.pma;
  assign pm_wdata = s_reg.pmw;
  assign pm_we = s_reg.pmwe;
  assign z_wdata = s_reg.zw;
  assign z_we = s_reg.zwe;
  assign status_flags_register = s_reg.flags;
  assign stack_ptr = s_reg.sp;
  assign break_req = s_reg.brk;
  assign sleep_req = s_reg.slp;
  assign watchdog_restart = s_reg.wdog;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence take_op(cbx_op_t o);
    take && op_code == o;
  endsequence

  sequence ce_three;
    ce [*3];
  endsequence

  io_flags_kept_a: assert property ((take_op(CBX_OP_IN) or take_op(CBX_OP_OUT)) |=>
    status_flags_register == $past(status_flags_register) && op_done)
    else $error("io transfer changed flags or took more than one cycle");

  push_one_cycle_a: assert property (take_op(CBX_OP_PUSH) |=>
    dmem_we && op_done && stack_ptr == $past(stack_ptr) - AW'(1))
    else $error("push did not finish in one cycle");

  pop_int_three_a: assert property (take_op(CBX_OP_POP) ##0 !dmem_external ##1 ce_three |->
    op_done && rd_we && !$past(op_done))
    else $error("internal pop not done after three cycles");

  shl_result_a: assert property (take_op(CBX_OP_SHL) |=>
    rd_wdata == {$past(op_reg[DW-2:0]), 1'b0} &&
    status_flags_register[CBX_FLAG_C] == $past(op_reg[DW-1]))
    else $error("left shift result or carry wrong");

  sra_keep_msb_a: assert property (take_op(CBX_OP_SRA) |=>
    rd_wdata[DW-1] == $past(op_reg[DW-1]) &&
    status_flags_register[CBX_FLAG_C] == $past(op_reg[0]))
    else $error("arithmetic right shift wrong");

  ioset_bit_a: assert property (take_op(CBX_OP_IOSET) |=>
    io_we && io_wdata == ($past(io_rdata) | bit_mask($past(op_bit))) &&
    status_flags_register == $past(status_flags_register))
    else $error("io bit set wrong");

  ioclr_bit_a: assert property (take_op(CBX_OP_IOCLR) |=>
    io_we && io_wdata == ($past(io_rdata) & ~bit_mask($past(op_bit))) &&
    status_flags_register == $past(status_flags_register))
    else $error("io bit clear wrong");

  tstore_only_t_a: assert property (take_op(CBX_OP_TSTORE) |=>
    status_flags_register[CBX_FLAG_T] == $past(op_reg[op_bit]) &&
    (status_flags_register | bit_mask(3'(CBX_FLAG_T))) ==
    ($past(status_flags_register) | bit_mask(3'(CBX_FLAG_T))))
    else $error("bit store touched other flags");

  tload_bit_a: assert property (take_op(CBX_OP_TLOAD) |=>
    rd_wdata[$past(op_bit)] == $past(status_flags_register[CBX_FLAG_T]) &&
    status_flags_register == $past(status_flags_register))
    else $error("bit load wrong");

  fset_named_a: assert property (take_op(CBX_OP_FSET) |=>
    status_flags_register == ($past(status_flags_register) | bit_mask($past(op_bit))))
    else $error("flag set wrong");

  fclr_named_a: assert property (take_op(CBX_OP_FCLR) |=>
    status_flags_register == ($past(status_flags_register) & ~bit_mask($past(op_bit))))
    else $error("flag clear wrong");

  mcu_pulse_a: assert property (take_op(CBX_OP_SLEEP) |=>
    sleep_req && op_done ##1 (!$past(ce) || !sleep_req))
    else $error("sleep request not a one-cycle pulse");

  pm_stall_a: assert property (s_reg.st == CBX_ST_PMW && !pm_done |=> !op_done)
    else $error("program store finished without completion");

  pm_step_a: assert property (s_reg.st == CBX_ST_PMW && pm_done && ce |=>
    z_we && z_wdata == $past(z_val) + CBX_PM_STEP)
    else $error("pointer not advanced by two");
endmodule
`default_nettype wire

// [test/cbx_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Data memory, I/O space and flash stand-in
// ----------------------------------------
module cbx_mem_model (
  input wire logic clk,
  input wire logic [31:0] pm_lat,
  input wire logic [5:0] op_io_addr,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  output logic [7:0] io_rdata,
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [7:0] dmem_rdata,
  output logic dmem_ready,
  input wire logic pm_we,
  output logic pm_done
);
  logic [7:0] io_mem [64];
  logic [7:0] dm [16];
  logic [31:0] cnt;
  initial begin
    for (int i = 0; i < 64; i++) begin
      io_mem[i] = 8'h00;
    end
    dmem_rdata = 8'h00;
    pm_done = 1'b0;
    dmem_ready = 1'b0;
    cnt = 0;
  end
  assign io_rdata = io_mem[op_io_addr];
  always @(posedge clk) begin
    // External RAM answers with its data one cycle after the strobe
    dmem_ready <= dmem_re;
    if (io_we) begin
      io_mem[io_addr] <= io_wdata;
    end
    if (dmem_we) begin
      dm[dmem_addr[3:0]] <= dmem_wdata;
    end
    // Read data stands one cycle, then goes stale so late sampling shows
    if (dmem_re) begin
      dmem_rdata <= dm[dmem_addr[3:0]];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
    pm_done <= 1'b0;
    if (pm_we) begin
      cnt <= pm_lat;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        pm_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/cbx_exec_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cbx_exec_test;
  import cbx_pkg::*;
  logic clk, rstn, ce, op_valid, op_ready, dmem_external, dmem_ready, pm_done, op_done;
  cbx_op_t op_code;
  logic [7:0] op_reg, r0_val, r1_val, z_ext, io_rdata, dmem_rdata, rd_wdata, io_wdata;
  logic [7:0] dmem_wdata, flags, f;
  logic [2:0] op_bit;
  logic [5:0] op_io_addr, io_addr;
  logic [15:0] z_val, dmem_addr, pm_wdata, z_wdata, sp;
  logic [23:0] pm_addr;
  logic rd_we, io_we, dmem_we, dmem_re, pm_we, z_we, brk, slp, wdog;
  logic [31:0] pm_lat;
  int n_fail, check_count, cyc, tick;

  cbx_exec u_cbx_exec (.clk(clk), .rstn(rstn), .ce(ce), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_reg(op_reg), .op_bit(op_bit),
    .op_io_addr(op_io_addr), .r0_val(r0_val), .r1_val(r1_val), .z_val(z_val),
    .z_pointer_extension(z_ext), .io_rdata(io_rdata), .dmem_rdata(dmem_rdata),
    .dmem_external(dmem_external), .dmem_ready(dmem_ready), .pm_done(pm_done),
    .op_done(op_done), .rd_wdata(rd_wdata), .rd_we(rd_we), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .dmem_re(dmem_re), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .pm_we(pm_we), .z_wdata(z_wdata), .z_we(z_we), .status_flags_register(flags),
    .stack_ptr(sp), .break_req(brk), .sleep_req(slp), .watchdog_restart(wdog));

  cbx_mem_model u_cbx_mem_model (.clk(clk), .pm_lat(pm_lat), .op_io_addr(op_io_addr),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_rdata(io_rdata),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
    .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready),
    .pm_we(pm_we), .pm_done(pm_done));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 5000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Idle edge first so op_valid is never assigned twice in one step
  task automatic run(input cbx_op_t op, input logic [7:0] r, input logic [2:0] b,
                     input logic [5:0] a);
    @(posedge clk);
    #1;
    op_code = op;
    op_reg = r;
    op_bit = b;
    op_io_addr = a;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    cyc = 1;
    while (op_done !== 1'b1 && cyc < 40) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      f = flags;
      run(CBX_OP_FSET, 8'h00, 3'(i), 6'h00);
      chk("flag set", {16'h0000, f | (8'h01 << i)}, {16'h0000, flags});
      chk("flag set cycles", 24'h1, 24'(cyc));
      run(CBX_OP_FCLR, 8'h00, 3'(i), 6'h00);
      chk("flag clear", {16'h0000, f & ~(8'h01 << i)}, {16'h0000, flags});
    end
  endtask

  task automatic t_shift;
    cbx_op_t op;
    logic [7:0] v, r, e;
    logic co;
    for (int o = 0; o < 5; o++) begin
      for (int k = 0; k < 8; k++) begin
        op = cbx_op_t'(CBX_OP_SHL + o);
        v = (k < 2) ? 8'h81 : (k < 4) ? 8'h80 : (k < 6) ? 8'h48 : 8'h01;
        run((k % 2) ? CBX_OP_FSET : CBX_OP_FCLR, 8'h00, 3'(CBX_FLAG_C), 6'h00);
        f = flags;
        case (op)
          CBX_OP_SHL: {co, r} = {v, 1'b0};
          CBX_OP_ROTL: {co, r} = {v, f[CBX_FLAG_C]};
          CBX_OP_SHR: {r, co} = {1'b0, v};
          CBX_OP_ROTR: {r, co} = {f[CBX_FLAG_C], v};
          default: {r, co} = {v[7], v};
        endcase
        e = f;
        e[CBX_FLAG_C] = co;
        e[CBX_FLAG_Z] = (r == 8'h00);
        e[CBX_FLAG_N] = r[7];
        e[CBX_FLAG_V] = r[7] ^ co;
        if (op == CBX_OP_SHL || op == CBX_OP_ROTL) begin
          e[CBX_FLAG_H] = v[3];
        end
        run(op, v, 3'h0, 6'h00);
        chk("shift result", {16'h0000, r}, {16'h0000, rd_wdata});
        chk("shift flags", {16'h0000, e}, {16'h0000, flags});
        chk("shift write", {23'h0, 1'b1}, {23'h0, rd_we});
        chk("shift cycles", 24'h1, 24'(cyc));
      end
    end
  endtask

  task automatic t_bits;
    f = flags & 8'hbf;
    run(CBX_OP_FCLR, 8'h00, 3'(CBX_FLAG_T), 6'h00);
    run(CBX_OP_SWAP, 8'h3c, 3'h0, 6'h00);
    chk("swap", {16'h0000, 8'hc3}, {16'h0000, rd_wdata});
    chk("swap flags", {16'h0000, f}, {16'h0000, flags});
    run(CBX_OP_TSTORE, 8'h20, 3'h5, 6'h00);
    chk("store to T", {16'h0000, f | 8'h40}, {16'h0000, flags});
    run(CBX_OP_TLOAD, 8'h00, 3'h3, 6'h00);
    chk("load from T", {16'h0000, 8'h08}, {16'h0000, rd_wdata});
    chk("load flags", {16'h0000, f | 8'h40}, {16'h0000, flags});
    run(CBX_OP_TSTORE, 8'hef, 3'h4, 6'h00);
    chk("store zero to T", {16'h0000, f}, {16'h0000, flags});
    run(CBX_OP_TLOAD, 8'hff, 3'h3, 6'h00);
    chk("load zero", {16'h0000, 8'hf7}, {16'h0000, rd_wdata});
    chk("load cycles", 24'h1, 24'(cyc));
  endtask

  task automatic t_io;
    f = flags;
    run(CBX_OP_OUT, 8'ha5, 3'h0, 6'h15);
    chk("out", {10'h0, 1'b1, 6'h15, 8'ha5}, {10'h0, io_we, io_addr, io_wdata});
    chk("out cycles", 24'h1, 24'(cyc));
    run(CBX_OP_IOSET, 8'h00, 3'h1, 6'h15);
    chk("bit set", {10'h0, 1'b1, 6'h15, 8'ha7}, {10'h0, io_we, io_addr, io_wdata});
    chk("bit set cycles", 24'h1, 24'(cyc));
    run(CBX_OP_IOCLR, 8'h00, 3'h0, 6'h15);
    chk("bit clear", {16'h0000, 8'ha6}, {16'h0000, io_wdata});
    chk("bit clear cycles", 24'h1, 24'(cyc));
    run(CBX_OP_IN, 8'h00, 3'h0, 6'h15);
    chk("in", {15'h0, 1'b1, 8'ha6}, {15'h0, rd_we, rd_wdata});
    chk("in cycles", 24'h1, 24'(cyc));
    chk("io flags", {16'h0000, f}, {16'h0000, flags});
  endtask

  task automatic t_stack;
    f = flags;
    run(CBX_OP_PUSH, 8'h5a, 3'h0, 6'h00);
    chk("push", {1'b1, 7'h0, 16'h3fff}, {dmem_we, 7'h0, dmem_addr});
    chk("push data", {8'h0, 16'h3ffe, 8'h5a}, {8'h0, sp, dmem_wdata});
    chk("push cycles", 24'h1, 24'(cyc));
    run(CBX_OP_PUSH, 8'hc3, 3'h0, 6'h00);
    chk("push sp", {8'h0, 16'h3ffd}, {8'h0, sp});
    run(CBX_OP_POP, 8'h00, 3'h0, 6'h00);
    chk("pop cycles", 24'h3, 24'(cyc));
    chk("pop data", {15'h0, 1'b1, 8'hc3}, {15'h0, rd_we, rd_wdata});
    chk("pop addr", {8'h0, 16'h3ffe}, {8'h0, dmem_addr});
    run(CBX_OP_POP, 8'h00, 3'h0, 6'h00);
    chk("pop data", {16'h0, 8'h5a}, {16'h0, rd_wdata});
    chk("pop sp", {8'h0, 16'h3fff}, {8'h0, sp});
    chk("stack flags", {16'h0000, f}, {16'h0000, flags});
    // External RAM in the model adds one wait state to the two-cycle pop
    dmem_external = 1'b1;
    run(CBX_OP_PUSH, 8'h77, 3'h0, 6'h00);
    run(CBX_OP_POP, 8'h00, 3'h0, 6'h00);
    chk("ext pop cycles", 24'h3, 24'(cyc));
    chk("ext pop data", {15'h0, 1'b1, 8'h77}, {15'h0, rd_we, rd_wdata});
    dmem_external = 1'b0;
  endtask

  task automatic t_pm(input int lat);
    pm_lat = lat;
    r0_val = 8'h34;
    r1_val = 8'h12;
    z_val = 16'hfffe;
    z_ext = 8'h01;
    f = flags;
    run(CBX_OP_PMSTORE, 8'h00, 3'h0, 6'h00);
    chk("store cycles", 24'(lat + 3), 24'(cyc));
    chk("store addr", 24'h01fffe, pm_addr);
    chk("store word", {8'h0, 16'h1234}, {8'h0, pm_wdata});
    chk("pointer", {7'h0, 1'b1, 16'h0000}, {7'h0, z_we, z_wdata});
    chk("store flags", {16'h0000, f}, {16'h0000, flags});
  endtask

  task automatic t_mcu;
    cbx_op_t op;
    for (int k = 0; k < 4; k++) begin
      op = (k == 0) ? CBX_OP_NOP : cbx_op_t'(CBX_OP_BRK + k - 1);
      f = flags;
      run(op, 8'h00, 3'h0, 6'h00);
      chk("control pulse", 24'((k == 0) ? 0 : 8 >> k), {21'h0, brk, slp, wdog});
      chk("control cycles", 24'h1, 24'(cyc));
      chk("control flags", {16'h0000, f}, {16'h0000, flags});
    end
  endtask

  // Enable low: an offered operation is not taken and nothing moves
  task automatic t_hold;
    @(posedge clk);
    #1;
    f = flags;
    ce = 1'b0;
    run(CBX_OP_FSET, 8'h00, 3'(CBX_FLAG_I), 6'h00);
    chk("frozen flags", {16'h0000, f}, {16'h0000, flags});
    chk("frozen wait", 24'h28, 24'(cyc));
    ce = 1'b1;
    run(CBX_OP_FSET, 8'h00, 3'(CBX_FLAG_I), 6'h00);
    chk("enabled flags", {16'h0000, f | (8'h01 << CBX_FLAG_I)}, {16'h0000, flags});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    op_valid = 1'b0;
    op_code = CBX_OP_NOP;
    op_reg = 8'h00;
    op_bit = 3'h0;
    op_io_addr = 6'h00;
    r0_val = 8'h00;
    r1_val = 8'h00;
    z_val = 16'h0000;
    z_ext = 8'h00;
    dmem_external = 1'b0;
    pm_lat = 1;
    n_fail = 0;
    check_count = 0;
    tick = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("reset", {CBX_FLAGS_RST, CBX_SP_RST}, {flags, sp});
    chk("reset ready", {23'h0, 1'b1}, {23'h0, op_ready});
    t_flags();
    t_shift();
    t_bits();
    t_io();
    t_stack();
    t_pm(1);
    t_pm(6);
    t_mcu();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire
